/* rtl/fdr_core.sv */
// Fault detection, prioritisation and reporting for the switch matrix driver
`include "fdr_regs.svh"

module fdr_core
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial port pins, already in the clock domain
  input wire fdr_pkg::fdr_spi_t spi_i,
  // Converter handshake
  input wire fdr_pkg::fdr_conv_t conv_i,
  input wire logic direction_i,
  input wire logic direction_return_i,
  // Sequencer status
  input wire fdr_pkg::fdr_seq_t seq_i,
  input wire logic reference_ok_i,
  // Fault reporting
  output logic fault_int_o,
  output logic [3:0] fault_code_o,
  output logic code_load_o,
  output logic open_all_o
);

  // Edge detection on the watched inputs
  logic [`FDR_WATCH_W-1:0] watch;
  logic [`FDR_WATCH_W-1:0] watch_ff;
  logic [`FDR_WATCH_W-1:0] rise;
  logic [`FDR_WATCH_W-1:0] fall;

  assign watch = {spi_i.cs_n, spi_i.sclk, conv_i.done, reference_ok_i};

  genvar gi;
  generate
    for (gi = 0; gi < `FDR_WATCH_W; gi++)
    begin : g_edge
      assign rise[gi] = watch[gi] & ~watch_ff[gi];
      assign fall[gi] = ~watch[gi] & watch_ff[gi];
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      watch_ff <= `FDR_WATCH_RST;
    end
    else
    begin
      watch_ff <= watch;
    end
  end

  // Named edges
  logic cs_fall;
  logic in_txn;
  logic sclk_rise;
  logic done_rise;
  logic ref_fall;

  assign cs_fall = fall[3];
  assign in_txn = ~spi_i.cs_n;
  assign sclk_rise = rise[2] & in_txn;
  assign done_rise = rise[1];
  assign ref_fall = fall[0];

  // Transaction phase and edge counter
  fdr_pkg::fdr_phase_t phase_ff;
  fdr_pkg::fdr_phase_t nxt_phase;
  logic [`FDR_EDGE_W-1:0] edge_cnt_ff;
  logic [`FDR_EDGE_W-1:0] nxt_edge_cnt;

  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_edge_cnt = edge_cnt_ff;
    if (cs_fall)
    begin
      nxt_phase = fdr_pkg::FDR_HEAD;
      nxt_edge_cnt = '0;
    end
    else if (!in_txn)
    begin
      nxt_phase = fdr_pkg::FDR_IDLE;
    end
    else if (sclk_rise)
    begin
      unique case (phase_ff)
        fdr_pkg::FDR_IDLE:
        begin
          nxt_phase = fdr_pkg::FDR_IDLE;
        end
        fdr_pkg::FDR_HEAD:
        begin
          nxt_edge_cnt = edge_cnt_ff + `FDR_EDGE_W'(1);
          if (nxt_edge_cnt == `FDR_LOW_BITS)
          begin
            nxt_phase = fdr_pkg::FDR_BODY;
          end
        end
        fdr_pkg::FDR_BODY:
        begin
          nxt_edge_cnt = edge_cnt_ff + `FDR_EDGE_W'(1);
          if (nxt_edge_cnt == `FDR_LAST_EDGE)
          begin
            nxt_phase = fdr_pkg::FDR_OVER;
          end
        end
        fdr_pkg::FDR_OVER:
        begin
          // Counter saturates; every further edge is an excess edge
          nxt_phase = fdr_pkg::FDR_OVER;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_ff <= fdr_pkg::FDR_IDLE;
      edge_cnt_ff <= '0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      edge_cnt_ff <= nxt_edge_cnt;
    end
  end

  // Serial faults
  logic excess_edge;
  logic bad_high;
  logic serial_evt;

  assign excess_edge = sclk_rise & (phase_ff == fdr_pkg::FDR_OVER);
  assign bad_high = sclk_rise & (phase_ff == fdr_pkg::FDR_HEAD) & spi_i.sdi;
  assign serial_evt = excess_edge | bad_high;

  // A bad leading bit lands before the clearing rise of the same frame;
  // remembering it keeps it from being wiped before it can be reported
  logic frame_fault_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frame_fault_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      frame_fault_ff <= 1'b0;
    end
    else if (serial_evt)
    begin
      frame_fault_ff <= 1'b1;
    end
  end

  // The clearing edge is the fifth rise, inside the allowed window
  logic clear_evt;

  assign clear_evt = sclk_rise & (phase_ff == fdr_pkg::FDR_BODY) &
                     (edge_cnt_ff == `FDR_CLR_EDGE);

  // Direction fault; the return must be the complement, checked only while select is high
  logic dir_evt;

  assign dir_evt = ~in_txn & (direction_return_i == direction_i);

  // Converter faults are blanked from select fall until direction is set,
  // which also covers the span up to the enable fall
  logic conv_mask_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conv_mask_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      conv_mask_ff <= 1'b1;
    end
    else if (seq_i.dir_set)
    begin
      conv_mask_ff <= 1'b0;
    end
  end

  logic conv_evt;

  assign conv_evt = done_rise & conv_i.en & ~conv_mask_ff & ~in_txn;

  // Undervoltage while active
  logic undervoltage_lockout_evt;

  assign undervoltage_lockout_evt = ref_fall & seq_i.active;

  logic any_evt;

  assign any_evt = conv_evt | serial_evt | dir_evt | undervoltage_lockout_evt;

  // Pending fault conditions, set wins over the clear
  fdr_pkg::fdr_pend_t pend_ff;
  fdr_pkg::fdr_pend_t nxt_pend;
  logic [2:0] conv_code_ff;
  logic fault_int_ff;
  logic nxt_fault_int;

  always_comb
  begin
    nxt_pend = pend_ff;
    if (clear_evt)
    begin
      nxt_pend = '0;
      nxt_pend.serial = frame_fault_ff;
    end
    if (conv_evt)
    begin
      nxt_pend.conv = 1'b1;
    end
    if (serial_evt)
    begin
      nxt_pend.serial = 1'b1;
    end
    if (dir_evt)
    begin
      nxt_pend.dir = 1'b1;
    end
    if (undervoltage_lockout_evt)
    begin
      nxt_pend.undervoltage_lockout = 1'b1;
    end
  end

  assign nxt_fault_int = any_evt | (fault_int_ff & ~(clear_evt & ~frame_fault_ff));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_ff <= '0;
    end
    else
    begin
      pend_ff <= nxt_pend;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fault_int_ff <= 1'b0;
    end
    else
    begin
      fault_int_ff <= nxt_fault_int;
    end
  end

  // Keep the code of the first converter fault until it is read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conv_code_ff <= `FDR_CONV_ZERO;
    end
    else if (conv_evt && !pend_ff.conv)
    begin
      conv_code_ff <= conv_i.code;
    end
  end

  // Sequencing faults seen at the select fall itself
  logic seq_wait_done;
  logic seq_settle;
  logic seq_ref;

  assign seq_wait_done = seq_i.wait_done;
  assign seq_settle = ~seq_i.switch_settle | seq_i.wait_settle;
  assign seq_ref = ~reference_ok_i & (seq_i.cmd != `FDR_CMD_OPEN_ALL);

  // Converter code form
  logic [3:0] conv_report;

  assign conv_report = (conv_code_ff == `FDR_CONV_ZERO) ?
                       `FDR_CODE_CONV0 : {1'b0, conv_code_ff};

  // Priority selection, highest first
  logic [3:0] sel_code;

  assign sel_code =
    pend_ff.conv   ? conv_report :
    pend_ff.serial ? `FDR_CODE_SERIAL :
    pend_ff.dir    ? `FDR_CODE_DIR :
    seq_wait_done  ? `FDR_CODE_WAIT_DONE :
    seq_settle     ? `FDR_CODE_SETTLE :
    seq_ref        ? `FDR_CODE_REF :
    pend_ff.undervoltage_lockout   ? `FDR_CODE_REF :
    `FDR_CODE_NONE;

  // Code is captured at the select fall so it goes out in this transaction;
  // sequencing faults never touch the flag
  logic [3:0] fault_code_ff;
  logic code_load_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fault_code_ff <= `FDR_CODE_NONE;
    end
    else if (cs_fall)
    begin
      fault_code_ff <= sel_code;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_load_ff <= 1'b0;
    end
    else
    begin
      code_load_ff <= cs_fall;
    end
  end

  // Open-all request fires on the same edge the flag rises
  logic open_all_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      open_all_ff <= 1'b0;
    end
    else
    begin
      open_all_ff <= nxt_fault_int & ~fault_int_ff;
    end
  end

  assign fault_int_o = fault_int_ff;
  assign fault_code_o = fault_code_ff;
  assign code_load_o = code_load_ff;
  assign open_all_o = open_all_ff;

endmodule

/* shared/fdr_regs.svh */
// Constants of the fault detection and reporting block
//
// Contract
// - A ninth serial clock rise while select is low is a serial fault; flag set.
// - Data input high in any of the four must-be-low bits is a serial fault.
// - Direction return equal to driven direction is a fault, masked during transactions.
// - Converter finished rising while converter enable is high is a converter fault.
// - Converter faults from transaction start to enable fall are never reported.
// - Reference-good falling while active sets the fault flag.
// - Unfinished previous sequence at select fall reports at once, flag untouched.
// - Select fall while waiting for converter finished edge reports code 1000.
// - Select fall while switch settle is low or awaited reports code 1001.
// - Select fall with reference low and command not open-all reports 1011.
// - Flag clears between the fourth and sixth serial clock rises.
// - Converter faults from select fall until direction is set are ignored.
// - Only the highest code is reported: converter, serial, direction, sequencing; else 1010. The code reports a pending undervoltage as 1011 after these.
// - Converter fault reports zero plus converter code, or 1100 when code is zero.
// - Serial faults report code 1101.
// - Direction return not complementing direction reports code 1110.
// - Flag rising forces an open-all-switches request at once.
// - Reading the code clears the pending fault condition.
`ifndef FDR_REGS_SVH
`define FDR_REGS_SVH

// Serial framing: FDR_CLR_EDGE is matched against the count before its edge, the others against the count after it
`define FDR_EDGE_W 4
`define FDR_LAST_EDGE 4'h8
`define FDR_LOW_BITS 4'h4
`define FDR_CLR_EDGE 4'h4

// Fault codes
`define FDR_CODE_CONV0 4'hc
`define FDR_CODE_SERIAL 4'hd
`define FDR_CODE_DIR 4'he
`define FDR_CODE_WAIT_DONE 4'h8
`define FDR_CODE_SETTLE 4'h9
`define FDR_CODE_REF 4'hb
`define FDR_CODE_NONE 4'ha
`define FDR_CMD_OPEN_ALL 4'h0
`define FDR_CONV_ZERO 3'h0

// Edge watch vector {select_n, serial clock, converter finished, reference ok}
`define FDR_WATCH_W 4
`define FDR_WATCH_RST 4'h9

`endif

/* shared/fdr_pkg.sv */
// Types of the fault detection and reporting block
package fdr_pkg;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } fdr_spi_t;

  typedef struct packed {
    logic en;
    logic done;
    logic [2:0] code;
  } fdr_conv_t;

  typedef struct packed {
    logic wait_done;
    logic wait_settle;
    logic switch_settle;
    logic dir_set;
    logic active;
    logic [3:0] cmd;
  } fdr_seq_t;

  typedef struct packed {
    logic conv;
    logic serial;
    logic dir;
    logic undervoltage_lockout;
  } fdr_pend_t;

  typedef enum logic [1:0] {
    FDR_IDLE,
    FDR_HEAD,
    FDR_BODY,
    FDR_OVER
  } fdr_phase_t;

endpackage

/* test/fdr_chk.sv */
// Assertions on the fault reporting core ports
module fdr_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched inputs
  input wire fdr_pkg::fdr_spi_t spi_i,
  input wire logic direction_i,
  input wire logic direction_return_i,
  input wire fdr_pkg::fdr_seq_t seq_i,
  input wire logic reference_ok_i,
  // Watched outputs
  input wire logic fault_int_o,
  input wire logic [3:0] fault_code_o,
  input wire logic code_load_o,
  input wire logic open_all_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Flag low at select fall means nothing flagged is pending
  sequence quiet_fall;
    $fell(spi_i.cs_n) && !fault_int_o;
  endsequence
  dir_fault_a:
    assert property (spi_i.cs_n && direction_return_i == direction_i |=> fault_int_o)
    else $error("direction fault not flagged");
  uv_flag_a:
    assert property ($fell(reference_ok_i) && seq_i.active |=> fault_int_o)
    else $error("undervoltage not flagged");
  open_pulse_a:
    assert property (open_all_o == $rose(fault_int_o))
    else $error("open request wrong");
  load_pulse_a:
    assert property ($fell(spi_i.cs_n) |-> ##1 code_load_o ##1 !code_load_o)
    else $error("code load wrong");
  code_hold_a:
    assert property (!$fell(spi_i.cs_n) |=> $stable(fault_code_o))
    else $error("code changed");
  flag_hold_a:
    assert property (fault_int_o && spi_i.cs_n |=> fault_int_o)
    else $error("flag dropped");
  wait_code_a:
    assert property (quiet_fall ##0 seq_i.wait_done |=> fault_code_o == 4'h8)
    else $error("wait code wrong");
  settle_code_a:
    assert property (quiet_fall ##0 !(seq_i.wait_done || seq_i.switch_settle)
      |=> fault_code_o == 4'h9) else $error("settle code wrong");
  cover property ($rose(fault_int_o));
  cover property (quiet_fall ##0 seq_i.wait_done);
  cover property (code_load_o && fault_code_o == 4'hd);
endmodule

bind fdr_core fdr_chk u_fdr_chk (.clk_i, .rst_i, .spi_i, .direction_i, .direction_return_i,
  .seq_i, .reference_ok_i, .fault_int_o, .fault_code_o, .code_load_o, .open_all_o);

/* test/fdr_far.sv */
// Far-side model of the converter direction echo
module fdr_far (
  // Direction echo
  input wire logic direction_i,
  input wire logic wrong_i,
  output logic direction_return_o
);
  assign direction_return_o = direction_i ^ ~wrong_i;
endmodule

/* test/tb_fault_detect_report.sv */
// Self-checking bench for the fault reporting core
module tb_fault_detect_report;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dir = 1'b0, wrong = 1'b0, ref_ok = 1'b1;
  logic dir_ret, fault;
  logic [3:0] code;
  fdr_pkg::fdr_spi_t spi = 3'h4;
  fdr_pkg::fdr_conv_t conv = 5'h0;
  // Settle high, else every frame reads a settle fault
  fdr_pkg::fdr_seq_t seq = 9'h040;
  int fail_count = 0, compares = 0;
  always #50 clk_i = ~clk_i;
  fdr_far u_fdr_far (.direction_i(dir), .wrong_i(wrong), .direction_return_o(dir_ret));
  fdr_core u_fdr_core (.clk_i, .rst_i, .spi_i(spi), .conv_i(conv), .direction_i(dir),
    .direction_return_i(dir_ret), .seq_i(seq), .reference_ok_i(ref_ok),
    .fault_int_o(fault), .fault_code_o(code), .code_load_o(), .open_all_o());
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic see(input logic e);
    repeat (2) @(negedge clk_i);
    chk({3'h0, fault}, {3'h0, e});
  endtask
  // Arm pulses direction set, which lifts the converter mask
  task automatic frame(input logic [7:0] b, input int n, input logic arm);
    @(negedge clk_i) spi.cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_i) spi = {2'b01, b[7 - i % 8]};
      @(negedge clk_i) spi.sclk = 1'b0;
    end
    @(negedge clk_i) spi = 3'h4;
    repeat (2) @(negedge clk_i);
    seq.dir_set = arm;
    @(negedge clk_i) seq.dir_set = 1'b0;
  endtask
  task automatic pulse(input logic [2:0] c);
    conv = {2'b10, c};
    @(negedge clk_i) conv.done = 1'b1;
    @(negedge clk_i) conv = 5'h0;
  endtask
  task automatic t_serial;
    chk(code, 4'ha);
    frame(8'h10, 8, 1'b1);
    see(1'b1);
    frame(8'h00, 9, 1'b1);
    chk(code, 4'hd);
    see(1'b1);
    frame(8'h00, 8, 1'b1);
    see(1'b0);
    $display("serial test done");
  endtask
  task automatic t_dir;
    dir = 1'b1;
    wrong = 1'b1;
    see(1'b1);
    wrong = 1'b0;
    frame(8'h00, 8, 1'b1);
    chk(code, 4'he);
    $display("direction test done");
  endtask
  task automatic t_conv;
    for (int c = 0; c < 8; c++)
    begin
      pulse(c[2:0]);
      see(1'b1);
      frame(8'h00, 8, 1'b1);
      chk(code, c == 0 ? 4'hc : {1'b0, c[2:0]});
    end
    wrong = 1'b1;
    pulse(3'h3);
    wrong = 1'b0;
    frame(8'h00, 8, 1'b0);
    chk(code, 4'h3);
    pulse(3'h5);
    see(1'b0);
    frame(8'h00, 8, 1'b1);
    chk(code, 4'ha);
    $display("converter test done");
  endtask
  task automatic t_seq;
    seq.wait_done = 1'b1;
    frame(8'h00, 8, 1'b1);
    chk(code, 4'h8);
    seq = 9'h001;
    frame(8'h00, 8, 1'b1);
    chk(code, 4'h9);
    seq = 9'h041;
    ref_ok = 1'b0;
    frame(8'h00, 8, 1'b1);
    chk(code, 4'hb);
    see(1'b0);
    ref_ok = 1'b1;
    seq.active = 1'b1;
    @(negedge clk_i) ref_ok = 1'b0;
    see(1'b1);
    $display("sequencing test done");
  endtask
  task automatic results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    t_serial;
    t_dir;
    t_conv;
    t_seq;
    results;
  end
  initial
  begin
    #1000000;
    fail_count++;
    results;
  end
endmodule
